// File: src/pcdg_pkg.sv
package pcdg_pkg;

  // ****************************************
  // Shift clock divide
  // ****************************************
  localparam logic [1:0] SEL_DIV4        = 2'h0;
  localparam logic [1:0] SEL_DIV8        = 2'h1;
  localparam logic [1:0] SEL_DIV16       = 2'h2;
  localparam logic [3:0] HALF_DIV4       = 4'h1;
  localparam logic [3:0] HALF_DIV8       = 4'h3;
  localparam logic [3:0] HALF_DIV16      = 4'h7;

  // ****************************************
  // Control register map
  // ****************************************
  localparam logic [7:0] OFS_MEM_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_POWER_SAVE  = 8'h08;
  localparam logic [7:0] OFS_DISP_ENABLE = 8'h09;
  localparam int         POS_PSAVE_EN    = 0;
  localparam int         POS_DISP_EN     = 0;
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'h58;
  localparam logic [7:0] RST_POWER_SAVE  = 8'h00;
  localparam logic [7:0] RST_DISP_ENABLE = 8'h00;

  // ****************************************
  // Timing and memory
  // ****************************************
  localparam int         PSAVE_MAX_FRAMES = 2;
  localparam int         MEM_BYTES        = 32768;
  localparam int         MEM_ADDR_W       = 15;

  typedef enum logic [1:0] {PCDG_OFF, PCDG_ON, PCDG_PSAVE_WAIT} pcdg_disp_state_t;

endpackage : pcdg_pkg

// File: src/pcdg_shift_div.sv
`timescale 1ns/1ns
module pcdg_shift_div (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       sync_clear_i,
  input  wire logic [1:0] shift_divider_select_i,
  output logic            panel_shift_clock_o,
  output logic            shift_rise_o
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       clk;
  } pcdg_div_t;

  pcdg_div_t s_q;
  pcdg_div_t s_d;
  logic [3:0] half_w;

  // ****************************************
  // Half period lookup
  // ****************************************
  always_comb begin
    unique case (shift_divider_select_i)
      pcdg_pkg::SEL_DIV4:  half_w = pcdg_pkg::HALF_DIV4;
      pcdg_pkg::SEL_DIV8:  half_w = pcdg_pkg::HALF_DIV8;
      pcdg_pkg::SEL_DIV16: half_w = pcdg_pkg::HALF_DIV16;
      default:             half_w = pcdg_pkg::HALF_DIV16;
    endcase
  end

  // ****************************************
  // Divider
  // ****************************************
  always_comb begin
    s_d = s_q;
    shift_rise_o = 1'b0;
    if (sync_clear_i) begin
      s_d.cnt = 4'h0;
      s_d.clk = 1'b0;
    end else if (s_q.cnt >= half_w) begin
      s_d.cnt = 4'h0;
      s_d.clk = ~s_q.clk;
      shift_rise_o = ~s_q.clk;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign panel_shift_clock_o = s_q.clk;

endmodule : pcdg_shift_div

// File: src/pcdg_top.sv
// Overview of operation
// - Shift clock period is 4, 8 or 16 system clocks for select 00, 01, 10.
// - Shift clock is divided from the system clock, edges aligned to it.
// - Power save under indirect addressing drops display enable within two frames.
// - Indirect display-off command 58h drops display enable within one clock.
// - Clearing display-enable bit under direct addressing drops output within two clocks.
// - Switching the display on raises display enable within two clocks while power save is off.
// - Power save follows bit 0 of register 08h.
// - Display on or off follows bit 0 of register 09h.
// - Holds 32K bytes of on-chip memory for display, registers and patterns.
// - Write to register 00h resets timing, disables display, ends indirect power save.
`timescale 1ns/1ns
module pcdg_top (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] shift_divider_select_i,
  input  wire logic       indirect_mode_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic       frame_start_i,
  input  wire logic       mem_wr_i,
  input  wire logic [14:0] mem_addr_i,
  input  wire logic [7:0] mem_wdata_i,
  output logic [7:0]      mem_rdata_o,
  output logic            panel_shift_clock_o,
  output logic            panel_display_enable_out_o,
  output logic            power_save_o,
  output logic            timing_reset_o
);

  typedef struct packed {
    pcdg_pkg::pcdg_disp_state_t st;
    logic [7:0]                 psave_reg;
    logic [7:0]                 disp_reg;
    logic [1:0]                 frames;
    logic                       den;
    logic                       tim_rst;
    logic [7:0]                 rdata;
  } pcdg_state_t;

  pcdg_state_t s_q;
  pcdg_state_t s_d;
  logic [7:0]  mem_q [pcdg_pkg::MEM_BYTES];
  logic        cfg_wr_w;
  logic        psave_wr_w;
  logic        disp_wr_w;
  logic        off_cmd_w;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // ****************************************
  // Shift clock divider
  // ****************************************
  pcdg_shift_div u_div (
    .clk_sys_i              (clk_sys_i),
    .reset_n_i              (reset_n_i),
    .sync_clear_i           (s_q.tim_rst),
    .shift_divider_select_i (shift_divider_select_i),
    .panel_shift_clock_o    (panel_shift_clock_o),
    .shift_rise_o           ()
  );

  // ****************************************
  // Decode
  // ****************************************
  assign cfg_wr_w   = reg_wr_i && reg_hit(reg_addr_i, pcdg_pkg::OFS_MEM_CONFIG);
  assign psave_wr_w = reg_wr_i && reg_hit(reg_addr_i, pcdg_pkg::OFS_POWER_SAVE);
  assign disp_wr_w  = reg_wr_i && reg_hit(reg_addr_i, pcdg_pkg::OFS_DISP_ENABLE);
  assign off_cmd_w  = cmd_valid_i && indirect_mode_i && (cmd_code_i == pcdg_pkg::CMD_DISPLAY_OFF);

  // ****************************************
  // Display control
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.tim_rst = 1'b0;
    if (psave_wr_w) begin
      s_d.psave_reg = reg_wdata_i;
    end
    if (disp_wr_w) begin
      s_d.disp_reg = reg_wdata_i;
    end
    if (cfg_wr_w) begin
      s_d.tim_rst = 1'b1;
      s_d.disp_reg[pcdg_pkg::POS_DISP_EN] = 1'b0;
      if (indirect_mode_i) begin
        s_d.psave_reg[pcdg_pkg::POS_PSAVE_EN] = 1'b0;
      end
    end
    if (off_cmd_w) begin
      s_d.disp_reg[pcdg_pkg::POS_DISP_EN] = 1'b0;
    end
    unique case (s_q.st)
      pcdg_pkg::PCDG_OFF: begin
        s_d.den = 1'b0;
        if (s_q.disp_reg[pcdg_pkg::POS_DISP_EN] && !s_q.psave_reg[pcdg_pkg::POS_PSAVE_EN]
            && !off_cmd_w && !cfg_wr_w) begin
          s_d.st  = pcdg_pkg::PCDG_ON;
          s_d.den = 1'b1;
        end
      end
      pcdg_pkg::PCDG_ON: begin
        if (off_cmd_w || cfg_wr_w) begin
          s_d.st  = pcdg_pkg::PCDG_OFF;
          s_d.den = 1'b0;
        end else if (!s_q.disp_reg[pcdg_pkg::POS_DISP_EN]) begin
          s_d.st  = pcdg_pkg::PCDG_OFF;
          s_d.den = 1'b0;
        end else if (s_q.psave_reg[pcdg_pkg::POS_PSAVE_EN]) begin
          if (indirect_mode_i) begin
            s_d.st     = pcdg_pkg::PCDG_PSAVE_WAIT;
            s_d.frames = 2'h0;
          end else begin
            s_d.st  = pcdg_pkg::PCDG_OFF;
            s_d.den = 1'b0;
          end
        end
      end
      pcdg_pkg::PCDG_PSAVE_WAIT: begin
        if (off_cmd_w || cfg_wr_w || !s_q.disp_reg[pcdg_pkg::POS_DISP_EN]) begin
          s_d.st  = pcdg_pkg::PCDG_OFF;
          s_d.den = 1'b0;
        end else if (frame_start_i) begin
          s_d.frames = s_q.frames + 2'h1;
          if (s_q.frames == 2'(pcdg_pkg::PSAVE_MAX_FRAMES - 1)) begin
            s_d.st  = pcdg_pkg::PCDG_OFF;
            s_d.den = 1'b0;
          end
        end
      end
      default: begin
        s_d.st  = pcdg_pkg::PCDG_OFF;
        s_d.den = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q.st        <= pcdg_pkg::PCDG_OFF;
      s_q.psave_reg <= pcdg_pkg::RST_POWER_SAVE;
      s_q.disp_reg  <= pcdg_pkg::RST_DISP_ENABLE;
      s_q.frames    <= 2'h0;
      s_q.den       <= 1'b0;
      s_q.tim_rst   <= 1'b0;
      s_q.rdata     <= 8'h00;
    end else begin
      s_q       <= s_d;
      s_q.rdata <= mem_q[mem_addr_i];
    end
  end

  // ****************************************
  // Embedded memory
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (mem_wr_i) begin
      mem_q[mem_addr_i] <= mem_wdata_i;
    end
  end

  assign mem_rdata_o                = s_q.rdata;
  assign panel_display_enable_out_o = s_q.den;
  assign power_save_o               = s_q.psave_reg[pcdg_pkg::POS_PSAVE_EN];
  assign timing_reset_o             = s_q.tim_rst;

endmodule : pcdg_top

// File: testbench/pcdg_assertions.sv
`timescale 1ns/1ns
module pcdg_assertions (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic [1:0] shift_divider_select_i,
  input wire logic       indirect_mode_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic       frame_start_i,
  input wire logic       panel_shift_clock_o,
  input wire logic       panel_display_enable_out_o,
  input wire logic       power_save_o,
  input wire logic       timing_reset_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic       prev_q, seen_q;
  logic [1:0] sel_q, fcnt_q;
  logic [4:0] cnt_q, exp_w;
  logic       rise_w, cfg_w;
  assign rise_w = panel_shift_clock_o && !prev_q;
  assign cfg_w  = reg_wr_i && reg_addr_i == 8'h00;
  assign exp_w  = (shift_divider_select_i == 2'h0) ? 5'h04 : (shift_divider_select_i == 2'h1) ? 5'h08 : 5'h10;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {prev_q, seen_q, sel_q, fcnt_q, cnt_q} <= '0;
    end else begin
      prev_q <= panel_shift_clock_o;
      sel_q  <= shift_divider_select_i;
      cnt_q  <= rise_w ? 5'h01 : cnt_q + 5'h01;
      seen_q <= (rise_w || seen_q) && sel_q == shift_divider_select_i && !cfg_w && !timing_reset_o;
      if (!(power_save_o && indirect_mode_i)) fcnt_q <= 2'h0;
      else if (frame_start_i && fcnt_q != 2'h3) fcnt_q <= fcnt_q + 2'h1;
    end
  end
  sequence s_on_req;
    reg_wr_i && reg_addr_i == 8'h09 && reg_wdata_i[0] && !power_save_o;
  endsequence
  sequence s_off_req;
    reg_wr_i && reg_addr_i == 8'h09 && !reg_wdata_i[0] && !indirect_mode_i;
  endsequence
  a_shift_period: assert property (rise_w && seen_q |-> cnt_q == exp_w)
    else $error("shift clock period wrong");
  a_cmd_off: assert property (cmd_valid_i && cmd_code_i == 8'h58 && indirect_mode_i |=> !panel_display_enable_out_o)
    else $error("display off command late");
  a_direct_off: assert property (s_off_req |-> ##2 !panel_display_enable_out_o)
    else $error("direct display off late");
  a_disp_on: assert property (s_on_req |-> ##2 panel_display_enable_out_o)
    else $error("display on late");
  a_cfg_write: assert property (cfg_w |=> timing_reset_o && !panel_display_enable_out_o ##1 !timing_reset_o)
    else $error("config write effect wrong");
  a_psave_bit: assert property (reg_wr_i && reg_addr_i == 8'h08 |=> power_save_o == $past(reg_wdata_i[0]))
    else $error("power save bit wrong");
  a_psave_frames: assert property (fcnt_q == 2'h3 |-> !panel_display_enable_out_o)
    else $error("power save blank late");
  a_psave_block: assert property (power_save_o && !cfg_w |=> !$rose(panel_display_enable_out_o))
    else $error("display on during power save");
endmodule : pcdg_assertions
bind pcdg_top pcdg_assertions u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .shift_divider_select_i(shift_divider_select_i), .indirect_mode_i(indirect_mode_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .frame_start_i(frame_start_i), .panel_shift_clock_o(panel_shift_clock_o),
  .panel_display_enable_out_o(panel_display_enable_out_o), .power_save_o(power_save_o),
  .timing_reset_o(timing_reset_o));

// File: testbench/pcdg_panel_model.sv
`timescale 1ns/1ns
module pcdg_panel_model (
  input  wire logic clk_sys_i,
  input  wire logic panel_shift_clock_i,
  output logic [4:0] period_o
);
  logic       prev_q;
  logic [4:0] cnt_q;
  // Panel side measures shift clock period in system clocks
  always_ff @(posedge clk_sys_i) begin
    prev_q <= panel_shift_clock_i;
    if (panel_shift_clock_i && !prev_q) begin
      period_o <= cnt_q;
      cnt_q    <= 5'h01;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule : pcdg_panel_model

// File: testbench/pcdg_tb_top.sv
`timescale 1ns/1ns
module pcdg_tb_top;
  logic clk_sys_i, reset_n_i, ind, rwr, cv, fs, mwr, sclk, en, ps, tr;
  logic [1:0] sel;
  logic [7:0] ra, rd, cc, mwd, mrd;
  logic [14:0] ma;
  logic [4:0] per;
  int miscompares, check_count;
  pcdg_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .shift_divider_select_i(sel),
    .indirect_mode_i(ind), .reg_wr_i(rwr), .reg_addr_i(ra), .reg_wdata_i(rd), .cmd_valid_i(cv),
    .cmd_code_i(cc), .frame_start_i(fs), .mem_wr_i(mwr), .mem_addr_i(ma), .mem_wdata_i(mwd),
    .mem_rdata_o(mrd), .panel_shift_clock_o(sclk), .panel_display_enable_out_o(en),
    .power_save_o(ps), .timing_reset_o(tr));
  pcdg_panel_model u_panel (.clk_sys_i(clk_sys_i), .panel_shift_clock_i(sclk), .period_o(per));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys_i);
    #10;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ra = a; rd = d; rwr = 1'b1;
    step();
    rwr = 1'b0;
  endtask : wr
  task automatic cmd(input logic [7:0] c);
    cc = c; cv = 1'b1;
    step();
    cv = 1'b0;
  endtask : cmd
  task automatic t_shift;
    logic [4:0] exp[4] = '{5'h04, 5'h08, 5'h10, 5'h10};
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      wr(8'h00, 8'h00);
      chk("timing_reset", {7'h00, tr}, 8'h01);
      step(50);
      chk("shift_period", {3'h0, per}, {3'h0, exp[s]});
    end
    $display("test shift done");
  endtask : t_shift
  task automatic t_disp;
    wr(8'h09, 8'h01); step();
    chk("enable_on", {7'h00, en}, 8'h01);
    wr(8'h09, 8'h00); step();
    chk("enable_direct_off", {7'h00, en}, 8'h00);
    wr(8'h09, 8'h01); step(); ind = 1'b1;
    cmd(8'h58);
    chk("enable_cmd_off", {7'h00, en}, 8'h00);
    ind = 1'b0; wr(8'h09, 8'h01); step(); cmd(8'h58); step();
    chk("cmd_refused_direct", {7'h00, en}, 8'h01);
    wr(8'h00, 8'h00);
    chk("enable_cfg_off", {7'h00, en}, 8'h00);
    $display("test display done");
  endtask : t_disp
  task automatic t_psave;
    ind = 1'b1; wr(8'h09, 8'h01); step(); wr(8'h08, 8'h01);
    chk("psave_bit", {7'h00, ps}, 8'h01);
    for (int f = 0; f < 2; f++) begin
      step(20); fs = 1'b1; step(); fs = 1'b0;
    end
    step();
    chk("psave_blank", {7'h00, en}, 8'h00);
    wr(8'h09, 8'h01); step(2);
    chk("psave_blocks_on", {7'h00, en}, 8'h00);
    wr(8'h00, 8'h00); step();
    chk("psave_exit_cfg", {7'h00, ps}, 8'h00);
    ind = 1'b0;
    $display("test power save done");
  endtask : t_psave
  task automatic t_mem;
    ma = 15'h0000; mwd = 8'hA5; mwr = 1'b1; step(); ma = 15'h7FFF; mwd = 8'h3C; step(); mwr = 1'b0;
    step(); chk("mem_top", mrd, 8'h3C);
    ma = 15'h0000; step(2); chk("mem_low", mrd, 8'hA5);
    $display("test memory done");
  endtask : t_mem
  task automatic end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {reset_n_i, ind, rwr, cv, fs, mwr, sel, ra, rd, cc, mwd, ma} = '0;
    repeat (4) @(posedge clk_sys_i);
    #10 reset_n_i = 1'b1;
    t_shift(); t_disp(); t_psave(); t_mem();
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule : pcdg_tb_top
